// ==== verilog/spi_eeprom_core.sv ====
// Command decoder, write protection and serial engine of the EEPROM.
`timescale 1ns/1ps
module spi_eeprom_core
  import eeprom_pkg::*;
#(
  parameter int ADDR_W = 11,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic guard_n,
  output logic so,
  output logic so_oe
);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  // The array size picks 10 or 11 significant address bits.
  initial begin
    if (ADDR_W < 10 || ADDR_W > 11) begin
      $error("ADDR_W must be 10 or 11");
    end
    if (WRITE_CYCLES <= PAGE_BYTES) begin
      $error("WRITE_CYCLES must exceed the page size");
    end
  end

  // All registered state of the block.
  typedef struct packed {
    logic [2:0] cs_p;      // Synchroniser pipes, stage 0 first.
    logic [2:0] sck_p;
    logic [2:0] si_p;
    logic [2:0] hold_p;
    logic [2:0] wp_p;
    logic cs_f;            // Filtered pin levels.
    logic sck_f;
    logic si_f;
    logic hold_f;
    logic wp_f;
    phase_e ph;            // Sequence phase.
    logic [2:0] bitcnt;    // Bits taken in the current byte.
    logic [6:0] shin;      // Serial input shifter.
    logic [7:0] tx;        // Serial output shifter.
    logic [1:0] tx_load;   // Countdown to array data arrival.
    logic [15:0] ad;       // Address as shifted in.
    logic abyte;           // Second address byte expected.
    logic is_wr;           // Address phase belongs to a write.
    logic got;             // At least one data byte taken.
    logic latch;           // Write enable latch.
    logic guard_en;        // Guard pin enable, cleared by reset.
    logic [1:0] lock;      // Block lock field.
    logic [7:0] sw_data;   // Status byte waiting for its cycle.
    logic busy;            // Internal write cycle running.
    logic is_swr;          // Running cycle is a status write.
    logic [CNT_W-1:0] wcnt;
    logic pend_set;        // Set-latch waiting for select to rise.
    logic pend_clr;
    logic guard_seen;      // Guard went active during status write.
    logic lat_we;
    logic [4:0] lat_idx;
    logic [7:0] lat_data;
    logic lat_clr;
    logic so_r;
    logic so_oe_r;
  } core_s;
  core_s r, n;

  store_if #(.ADDR_W(ADDR_W)) sif ();

  // A level counts once the last two stages agree.
  function automatic logic filt(input logic [2:0] p, input logic cur);
    filt = (p[1] == p[2]) ? p[2] : cur;
  endfunction : filt

  // True when an address lies in the region the lock field selects.
  function automatic logic locked(input logic [ADDR_W-1:0] a, input logic [1:0] lk);
    unique case (lk)
      LOCK_NONE: locked = 1'b0;
      LOCK_QUARTER: locked = &a[ADDR_W-1:ADDR_W-2];
      LOCK_HALF: locked = a[ADDR_W-1];
      default: locked = 1'b1;
    endcase
  endfunction : locked

  logic cs_rise, cs_fall, sck_rise, sck_fall, paused, byte_done, hw_guard;
  logic [7:0] rx, status;

  // Next-state logic for the whole block.
  always_comb begin
    n = r;
    n.cs_p = {r.cs_p[1:0], cs_n};
    n.sck_p = {r.sck_p[1:0], sck};
    n.si_p = {r.si_p[1:0], si};
    n.hold_p = {r.hold_p[1:0], hold_n};
    n.wp_p = {r.wp_p[1:0], guard_n};
    n.cs_f = filt(r.cs_p, r.cs_f);
    n.sck_f = filt(r.sck_p, r.sck_f);
    n.si_f = filt(r.si_p, r.si_f);
    n.hold_f = filt(r.hold_p, r.hold_f);
    n.wp_f = filt(r.wp_p, r.wp_f);
    n.lat_we = 1'b0;
    n.lat_clr = 1'b0;
    cs_rise = !r.cs_f && n.cs_f;
    cs_fall = r.cs_f && !n.cs_f;
    paused = !r.hold_f;
    // An sck edge seen in the same cycle as the select rise is dropped with the frame.
    sck_rise = !r.cs_f && !n.cs_f && !paused && !r.sck_f && n.sck_f;
    sck_fall = !r.cs_f && !n.cs_f && !paused && r.sck_f && !n.sck_f;
    byte_done = sck_rise && (r.bitcnt == 3'h7);
    rx = {r.shin, r.si_f};
    // Guard pin counts only with its enable set.
    // Enable clear leaves the pin ignored.
    hw_guard = r.guard_en && !r.wp_f;
    status = STAT_FIXED;
    status[GUARD_EN_BIT] = r.guard_en;
    status[LOCK_HI_BIT] = r.lock[1];
    status[LOCK_LO_BIT] = r.lock[0];
    status[LATCH_BIT] = r.latch;
    status[BUSY_BIT] = r.busy;

    // Self-timed write cycle; later commands cannot disturb it.
    if (r.busy) begin
      n.wcnt = r.wcnt + CNT_W'(1);
      if (r.wcnt == CNT_W'(WRITE_CYCLES - 1)) begin
        // Busy drops at the end of the cycle.
        n.busy = 1'b0;
        n.latch = 1'b0;
        if (r.is_swr) begin
          // Only bits 7, 3 and 2 change.
          n.guard_en = r.sw_data[GUARD_EN_BIT];
          n.lock = {r.sw_data[LOCK_HI_BIT], r.sw_data[LOCK_LO_BIT]};
        end
      end
    end

    // Array data arrives two clocks after the address moves.
    if (r.tx_load != 2'h0) begin
      n.tx_load = r.tx_load - 2'h1;
      if (r.tx_load == 2'h1) begin
        n.tx = sif.rd_data;
      end
    end

    // The branch follows the new select level, so the rise cycle commits here and the fall cycle starts a frame.
    if (n.cs_f) begin
      // Deselected: standby with the output floating.
      n.ph = PH_CMD;
      n.bitcnt = 3'h0;
      n.so_oe_r = 1'b0;
      if (cs_rise && !r.busy && r.bitcnt == 3'h0) begin
        // Set only once select has risen.
        if (r.pend_set) begin
          n.latch = 1'b1;
        end else if (r.pend_clr) begin
          n.latch = 1'b0;
        end
        if (r.ph == PH_WDATA && r.got) begin
          n.busy = 1'b1;
          n.is_swr = 1'b0;
          n.wcnt = '0;
        end
        // A guard fall during select cancels it.
        if (r.ph == PH_SWR && r.got && !r.guard_seen && !hw_guard) begin
          n.busy = 1'b1;
          n.is_swr = 1'b1;
          n.wcnt = '0;
        end
      end
    end else begin
      if (cs_fall) begin
        n.ph = PH_CMD;
        n.bitcnt = 3'h0;
        n.got = 1'b0;
        n.pend_set = 1'b0;
        n.pend_clr = 1'b0;
        n.guard_seen = 1'b0;
        n.abyte = 1'b0;
      end
      if (r.ph == PH_SWR && hw_guard) begin
        n.guard_seen = 1'b1;
      end
      // Input sampled on the rising clock.
      if (sck_rise) begin
        n.shin = rx[6:0];
        n.bitcnt = r.bitcnt + 3'h1;
      end
      // Output moves on the falling clock.
      if (sck_fall && (r.ph == PH_RDATA || r.ph == PH_SRD)) begin
        n.so_r = r.tx[7];
        n.tx = {r.tx[6:0], 1'b0};
      end
      if (byte_done) begin
        unique case (r.ph)
          PH_CMD: begin
            // Busy device takes only status reads.
            // Unknown codes lock out the sequence.
            n.ph = PH_IGNORE;
            if (rx == OP_STAT_RD) begin
              n.ph = PH_SRD;
              n.tx = status;
            end else if (!r.busy) begin
              unique case (rx)
                OP_SET_LATCH: n.pend_set = 1'b1;
                OP_CLR_LATCH: n.pend_clr = 1'b1;
                OP_READ: begin
                  n.ph = PH_ADDR;
                  n.is_wr = 1'b0;
                end
                OP_WRITE: begin
                  if (r.latch) begin
                    n.ph = PH_ADDR;
                    n.is_wr = 1'b1;
                    n.lat_clr = 1'b1;
                  end
                end
                OP_STAT_WR: begin
                  if (r.latch && !hw_guard) begin
                    n.ph = PH_SWR;
                  end
                end
                default: n.ph = PH_IGNORE;
              endcase
            end
          end
          PH_ADDR: begin
            // Two address bytes, low bits used.
            n.ad = {r.ad[7:0], rx};
            n.abyte = 1'b1;
            if (r.abyte) begin
              n.ph = r.is_wr ? PH_WDATA : PH_RDATA;
              n.tx_load = r.is_wr ? 2'h0 : 2'h2;
            end
          end
          PH_RDATA: begin
            n.ad[ADDR_W-1:0] = r.ad[ADDR_W-1:0] + ADDR_W'(1);
            n.tx_load = 2'h2;
          end
          PH_SRD: n.tx = status;
          PH_WDATA: begin
            // Locked bytes never reach the latch.
            if (!locked(r.ad[ADDR_W-1:0], r.lock)) begin
              n.lat_we = 1'b1;
              n.lat_idx = r.ad[PAGE_W-1:0];
              n.lat_data = rx;
            end
            n.ad[PAGE_W-1:0] = r.ad[PAGE_W-1:0] + PAGE_W'(1);
            n.got = 1'b1;
          end
          PH_SWR: begin
            n.sw_data = rx;
            n.got = 1'b1;
          end
          PH_IGNORE: n.ph = PH_IGNORE;
        endcase
      end
      // Floating once the opcode was refused.
      n.so_oe_r = !paused && (n.ph == PH_RDATA || n.ph == PH_SRD);
    end
  end

  // Power-up leaves the latch clear and output floating.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.cs_p <= 3'h7;
      r.hold_p <= 3'h7;
      r.wp_p <= 3'h7;
      r.cs_f <= 1'b1;
      r.hold_f <= 1'b1;
      r.wp_f <= 1'b1;
      r.ph <= PH_CMD;
    end else begin
      r <= n;
    end
  end

  assign sif.rd_addr = r.ad[ADDR_W-1:0];
  assign sif.lat_we = r.lat_we;
  assign sif.lat_idx = r.lat_idx;
  assign sif.lat_data = r.lat_data;
  assign sif.lat_clr = r.lat_clr;
  assign sif.prog_en = r.busy && !r.is_swr && (r.wcnt < CNT_W'(PAGE_BYTES));
  assign sif.prog_idx = r.wcnt[PAGE_W-1:0];
  assign sif.page_base = r.ad[ADDR_W-1:PAGE_W];
  assign so = r.so_r;
  assign so_oe = r.so_oe_r;

  eeprom_store #(.ADDR_W(ADDR_W)) u_store (
    .clk(clk),
    .nrst(nrst),
    .sif(sif)
  );

  // Checks next to the logic they guard.
  chk_latch_set_cs: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r.latch) |-> $past(!r.cs_f) && r.cs_f && !r.busy)
    else $error("latch set without select rising");
  chk_latch_end_clr: assert property (@(posedge clk) disable iff (!nrst)
    $fell(r.busy) |-> !r.latch)
    else $error("latch left set after write cycle");
  chk_busy_bound: assert property (@(posedge clk) disable iff (!nrst)
    r.busy |-> r.wcnt < CNT_W'(WRITE_CYCLES))
    else $error("write cycle overran");
  chk_write_needs_latch: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r.busy) |-> $past(r.latch))
    else $error("write started without latch");
  chk_guard_blocks_sw: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r.busy) && r.is_swr |-> !$past(r.guard_seen) && !$past(hw_guard))
    else $error("status write passed the guard");
  chk_pause_float: assert property (@(posedge clk) disable iff (!nrst)
    !r.hold_f && !r.cs_f |=> !r.so_oe_r)
    else $error("output driven while paused");
  chk_ignore_float: assert property (@(posedge clk) disable iff (!nrst)
    r.ph == PH_IGNORE |-> !r.so_oe_r)
    else $error("output driven after refused opcode");
  chk_busy_cmd_ignored: assert property (@(posedge clk) disable iff (!nrst)
    byte_done && r.ph == PH_CMD && r.busy && rx != OP_STAT_RD |=> r.ph == PH_IGNORE)
    else $error("command taken while busy");
  chk_lock_no_latch: assert property (@(posedge clk) disable iff (!nrst)
    r.lat_we |-> !locked({r.ad[ADDR_W-1:PAGE_W], r.lat_idx}, r.lock))
    else $error("locked byte latched");
  chk_sw_bits: assert property (@(posedge clk) disable iff (!nrst)
    $fell(r.busy) && r.is_swr |-> r.guard_en == $past(r.sw_data[GUARD_EN_BIT]))
    else $error("status write lost its enable bit");
  chk_cs_float: assert property (@(posedge clk) disable iff (!nrst)
    r.cs_f |=> !r.so_oe_r)
    else $error("output driven while deselected");
  cov_read: cover property (@(posedge clk) disable iff (!nrst) r.ph == PH_RDATA && byte_done);
  cov_page_write: cover property (@(posedge clk) disable iff (!nrst) $rose(r.busy) && !r.is_swr);
  cov_status_write: cover property (@(posedge clk) disable iff (!nrst) $fell(r.busy) && r.is_swr);
  cov_pause: cover property (@(posedge clk) disable iff (!nrst) !r.hold_f && r.ph == PH_RDATA);
endmodule : spi_eeprom_core

// ==== verilog/eeprom_pkg.sv ====
// Shared constants for the serial EEPROM command and protection logic.
package eeprom_pkg;
  // Command opcodes.
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // Status byte layout.
  localparam int GUARD_EN_BIT = 7;
  localparam int LOCK_HI_BIT = 3;
  localparam int LOCK_LO_BIT = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] STAT_FIXED = 8'h20;
  // Block lock codes.
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_QUARTER = 2'h1;
  localparam logic [1:0] LOCK_HALF = 2'h2;
  // Page geometry.
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  // Clock rate and self-timed write cycle length.
  localparam int CLK_MHZ = 50;
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
  // Serial sequence phases, Gray coded in declaration order.
  typedef enum logic [2:0] {
    PH_CMD = 3'h0,
    PH_ADDR = 3'h1,
    PH_WDATA = 3'h3,
    PH_RDATA = 3'h2,
    PH_SRD = 3'h6,
    PH_SWR = 3'h7,
    PH_IGNORE = 3'h5
  } phase_e;
endpackage : eeprom_pkg

// ==== verilog/store_if.sv ====
// Link between the command logic and the array store.
`timescale 1ns/1ps
interface store_if #(parameter int ADDR_W = 11);
  logic [ADDR_W-1:0] rd_addr;   // Array read address.
  logic [7:0] rd_data;          // Registered read data.
  logic lat_we;                 // Load one page latch byte.
  logic [4:0] lat_idx;          // Page latch index.
  logic [7:0] lat_data;         // Page latch byte.
  logic lat_clr;                // Empty the page latch.
  logic prog_en;                // Program one latched byte.
  logic [4:0] prog_idx;         // Byte being programmed.
  logic [ADDR_W-6:0] page_base; // Page being programmed.
  modport ctrl (output rd_addr, lat_we, lat_idx, lat_data, lat_clr, prog_en, prog_idx, page_base, input rd_data);
  modport store (input rd_addr, lat_we, lat_idx, lat_data, lat_clr, prog_en, prog_idx, page_base, output rd_data);
endinterface : store_if

// ==== verilog/eeprom_store.sv ====
// Byte array with a page latch and a registered read port.
`timescale 1ns/1ps
module eeprom_store
  import eeprom_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  input wire logic clk,
  input wire logic nrst,
  store_if.store sif
);
  // Registered state apart from the arrays.
  typedef struct packed {
    logic [7:0] rd_data;
    logic [PAGE_BYTES-1:0] mask;
  } store_s;
  store_s r, n;
  // The array holds its contents across reset, as the cells would.
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] lat [0:PAGE_BYTES-1];

  // Next state: read data and the per-byte fill mask.
  always_comb begin
    n = r;
    n.rd_data = mem[sif.rd_addr];
    if (sif.lat_clr) begin
      n.mask = '0;
    end else if (sif.lat_we) begin
      n.mask[sif.lat_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Latch and array writes; only filled latch bytes are programmed.
  always_ff @(posedge clk) begin
    if (sif.lat_we) begin
      lat[sif.lat_idx] <= sif.lat_data;
    end
    if (sif.prog_en && r.mask[sif.prog_idx]) begin
      mem[{sif.page_base, sif.prog_idx}] <= lat[sif.prog_idx];
    end
  end

  assign sif.rd_data = r.rd_data;
endmodule : eeprom_store

// ==== verification/spi_host_model.sv ====
// Behavioural SPI host that drives the EEPROM pins in mode 0.
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so_pin
);
  // Half of the 160 ns link clock period, four system clocks.
  localparam time HALF = 80ns;

  // Idle pins: deselected, clock low and no pause.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Select the device and give the sync pipes time to see it.
  task automatic sel();
    cs_n = 1'b0;
    #(HALF);
  endtask : sel

  task automatic desel();
    #(HALF);
    cs_n = 1'b1;
    // A released data line must not keep its last value.
    si = ~si;
    #(4 * HALF);
  endtask : desel

  // Bits go out MSB first, data read at the end of the high phase.
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si = tx[i];
      #(HALF);
      sck = 1'b1;
      #(HALF);
      // Sampling late keeps clear of the output's resync lag.
      rx[i] = so_pin;
      sck = 1'b0;
    end
  endtask : xfer

  // Pause and resume only while the clock is low.
  task automatic pause(input int n);
    hold_n = 1'b0;
    #(HALF);
    // Clock and data wiggle meanwhile; the device must ignore them.
    repeat (n) begin
      si = ~si;
      sck = 1'b1;
      #(HALF);
      sck = 1'b0;
      #(HALF);
    end
    hold_n = 1'b1;
    #(HALF);
  endtask : pause
endmodule : spi_host_model

// ==== verification/test_spi_eeprom_command_protect.sv ====
// Self-checking bench for the serial EEPROM command and protection core.
`timescale 1ns/1ps
module test_spi_eeprom_command_protect;
  import eeprom_pkg::*;
  // Shortened write cycle, long enough to probe the device while busy.
  localparam int WCYC = 2000;
  logic clk;
  logic nrst;
  logic guard_n;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe;
  wire logic so_pin;
  int fails = 0;
  int checked = 0;
  int hc = 0;            // System clocks spent paused.
  logic quiet = 1'b0;    // Set while the output must stay released.
  logic quiet_hit = 1'b0;
  logic [7:0] mem [0:2047]; // Expected array contents.
  logic [7:0] rx;
  logic latch_m = 1'b0;  // Expected write latch.
  logic busy_m = 1'b0;   // Expected busy flag.
  logic guard_en = 1'b0; // Expected guard pin enable.
  logic [1:0] lock = 2'h0;

  // The output line has a pull-up, so a released pin reads high.
  assign so_pin = so_oe ? so : 1'b1;

  // System clock, 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  spi_eeprom_core #(.ADDR_W(11), .WRITE_CYCLES(WCYC)) dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .guard_n(guard_n), .so(so), .so_oe(so_oe));
  spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_pin(so_pin));

  // Flags any driven output while refused or paused for a while.
  always @(posedge clk) begin
    hc <= hold_n ? 0 : hc + 1;
    if ((quiet || hc > 6) && so_oe !== 1'b0) quiet_hit <= 1'b1;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Compares one value and reports a difference.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Status byte the bench expects from its own state.
  function automatic logic [7:0] stat_exp();
    return {guard_en, 3'b010, lock, latch_m, busy_m};
  endfunction : stat_exp

  // True when an address lies in the locked region.
  function automatic logic locked(input logic [10:0] ad);
    case (lock)
      2'h0: return 1'b0;
      2'h1: return ad >= 11'h600;
      2'h2: return ad >= 11'h400;
      default: return 1'b1;
    endcase
  endfunction : locked

  // One-byte command in its own select.
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xfer(op, 8, rx);
    host.desel();
  endtask : cmd

  // Sets the latch; a busy device ignores it.
  task automatic latch_on();
    cmd(OP_SET_LATCH);
    latch_m = latch_m | !busy_m;
  endtask : latch_on

  // Reads the status byte.
  task automatic rd_status(output logic [7:0] s);
    host.sel();
    host.xfer(OP_STAT_RD, 8, rx);
    host.xfer(8'h00, 8, s);
    host.desel();
  endtask : rd_status

  // Reads the status byte and compares it with the expectation.
  task automatic stat_check();
    logic [7:0] s;
    rd_status(s);
    check("status", s, stat_exp());
  endtask : stat_check

  // Polls busy under a bound; the cycle leaves the latch clear.
  task automatic wait_ready();
    logic [7:0] s;
    s = 8'h01;
    for (int k = 0; k < 40 && s[0] !== 1'b0; k++) begin
      rd_status(s);
    end
    if (s[0] !== 1'b0) begin
      fails++;
      test_done();
    end
    busy_m = 1'b0;
    latch_m = 1'b0;
  endtask : wait_ready

  // Page write with random data; tail adds a broken byte.
  task automatic page_write(input logic [15:0] ad, input int n, input int tail);
    logic [7:0] d;
    logic [10:0] a;
    logic ok;
    ok = latch_m && !busy_m && tail == 0;
    host.sel();
    host.xfer(OP_WRITE, 8, rx);
    host.xfer(ad[15:8], 8, rx);
    host.xfer(ad[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom());
      a = {ad[10:5], 5'(ad[4:0] + i)};
      if (ok && !locked(a)) mem[a] = d;
      host.xfer(d, 8, rx);
    end
    if (tail > 0) host.xfer(8'h5a, tail, rx);
    host.desel();
    busy_m = busy_m | ok;
  endtask : page_write

  // Status write; refused without the latch or under the guard.
  task automatic wr_status(input logic [7:0] d);
    logic ok;
    ok = latch_m && !(guard_en && !guard_n);
    host.sel();
    host.xfer(OP_STAT_WR, 8, rx);
    host.xfer(d, 8, rx);
    host.desel();
    if (ok) begin
      guard_en = d[7];
      lock = d[3:2];
      busy_m = 1'b1;
      wait_ready();
    end
  endtask : wr_status

  // Streaming read with an optional pause before byte hold_at.
  task automatic read_check(input logic [15:0] ad, input int n, input int hold_at);
    logic [7:0] d;
    host.sel();
    host.xfer(OP_READ, 8, rx);
    host.xfer(ad[15:8], 8, rx);
    host.xfer(ad[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) host.pause(3);
      host.xfer(8'h00, 8, d);
      check("read data", d, mem[11'(ad + i)]);
    end
    host.desel();
  endtask : read_check

  // Main sequence.
  initial begin
    void'($urandom(32'hbd98));
    nrst = 1'b0;
    guard_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("idle enable", {7'h00, so_oe}, 8'h00);
    stat_check();
    latch_on();
    stat_check();
    cmd(OP_CLR_LATCH);
    latch_m = 1'b0;
    stat_check();
    // Top page written with overflow, then page zero.
    latch_on();
    page_write(16'hfffe, 34, 0);
    stat_check();
    wait_ready();
    stat_check();
    latch_on();
    page_write(16'h0000, 32, 0);
    wait_ready();
    read_check(16'hb7f0, 24, -1);
    // Without the latch, and with a broken last byte, nothing is written.
    page_write(16'h0000, 4, 0);
    latch_on();
    page_write(16'h0000, 2, 4);
    stat_check();
    read_check(16'h0000, 4, 2);
    // A write in the same select as the set-latch command is dropped.
    cmd(OP_CLR_LATCH);
    latch_m = 1'b0;
    host.sel();
    host.xfer(OP_SET_LATCH, 8, rx);
    host.xfer(OP_WRITE, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.xfer(8'hc3, 8, rx);
    host.desel();
    cmd(OP_CLR_LATCH);
    read_check(16'h0000, 1, -1);
    // While busy, writes and reads are ignored and status still answers.
    latch_on();
    page_write(16'h0100, 8, 0);
    stat_check();
    page_write(16'h0100, 8, 0);
    quiet = 1'b1;
    host.sel();
    host.xfer(OP_READ, 8, rx);
    host.xfer(8'h01, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.desel();
    quiet = 1'b0;
    wait_ready();
    read_check(16'h0100, 8, -1);
    latch_on();
    wr_status(8'hff);
    stat_check();
    latch_on();
    page_write(16'h0004, 4, 0);
    wait_ready();
    read_check(16'h0000, 8, -1);
    // Guard low with the enable set: status writes refused.
    guard_n = 1'b0;
    latch_on();
    wr_status(8'h84);
    stat_check();
    guard_n = 1'b1;
    wr_status(8'h84);
    guard_n = 1'b0;
    latch_on();
    page_write(16'h0008, 4, 0);
    wait_ready();
    latch_on();
    page_write(16'h07e0, 4, 0);
    wait_ready();
    read_check(16'h0000, 16, -1);
    read_check(16'h07e0, 4, -1);
    // Guard falling inside the select aborts the status write.
    guard_n = 1'b1;
    latch_on();
    host.sel();
    host.xfer(OP_STAT_WR, 8, rx);
    host.xfer(8'h00, 8, rx);
    guard_n = 1'b0;
    host.desel();
    stat_check();
    guard_n = 1'b1;
    wr_status(8'h08);
    guard_n = 1'b0;
    latch_on();
    wr_status(8'h00);
    stat_check();
    // An unknown opcode keeps the output released to the end of select.
    quiet = 1'b1;
    host.sel();
    host.xfer(8'ha5, 8, rx);
    host.xfer(OP_STAT_RD, 8, rx);
    host.desel();
    quiet = 1'b0;
    check("released output", {7'h00, quiet_hit}, 8'h00);
    stat_check();
    test_done();
  end
endmodule : test_spi_eeprom_command_protect
